// ==== rtl/twm_cfg.svh ====
/*
  Constants for the two-wire master transmitter: register offsets,
  control bit positions, status codes and bit timing.
  Assumes a 100 MHz pclk and an APB bus with byte addresses.
*/
`ifndef TWM_CFG_SVH
`define TWM_CFG_SVH
// How it works
// (R1) start needs enable, start and flag-clear
// (R2) start done: flag set, code 0x08
// (R3) address acked: 0x18, nacked 0x20, lost 0x38
// (R4) data write with flag low: collision
// (R5) software masks status with 0xF8
// (R6) flag set suspends transfer until cleared
// (R7) software sends byte: flag, enable only
// (R8) address direction bit selects master mode
// (R9) flag clear with stop sends stop
// (R10) start mid-transfer: repeated start, code 0x10
// (R11) read high, ack low, 8-bit bytes
// (R12) four modes, software picks legal ones
// (R13) arbitration lost: code 0x38, release bus
// (R14) stop plus start: stop, start; auto-clear
// (R15) no flag after stop sent
// (R16) flag set holds clock line low while bus owned

// register byte offsets
`define TWM_A_CTRL 8'h00
`define TWM_A_STAT 8'h04
`define TWM_A_DATA 8'h08
`define TWM_A_AUX 8'h0C
`define TWM_A_ISTAT 8'h10
`define TWM_A_IMASK 8'h14
// control bit positions
`define TWM_B_FLAG 7
`define TWM_B_STA 5
`define TWM_B_STO 4
`define TWM_B_EN 2
// status codes, prescaler bits zero
`define TWM_C_IDLE 8'hF8
`define TWM_C_START 8'h08
`define TWM_C_RSTART 8'h10
`define TWM_C_AACK 8'h18
`define TWM_C_ANACK 8'h20
`define TWM_C_DACK 8'h28
`define TWM_C_DNACK 8'h30
`define TWM_C_LOST 8'h38
`define TWM_M_CODE 8'hF8
// interrupt status bits
`define TWM_I_FLAG 0
`define TWM_I_LOST 1
`define TWM_I_WCOL 2
`define TWM_I_STOP 3
// bit timing: quarter of a 100 kHz bit
`define TWM_CLK_NS 10
`define TWM_QTR_NS 2500
`define TWM_QTR_CYC (`TWM_QTR_NS / `TWM_CLK_NS)
`define TWM_BITS 3'd7
`endif

// ==== rtl/twm_pkg.sv ====
/*
  Types of the two-wire master transmitter.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package twm_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_WAIT = 3'b001,
    S_START = 3'b010,
    S_BIT = 3'b011,
    S_ACK = 3'b100,
    S_HOLD = 3'b101,
    S_STOP = 3'b110
  } twm_state_t;

  // control register layout, msb first
  typedef struct packed {
    logic flag;
    logic acken;
    logic sta;
    logic sto;
    logic wc;
    logic en;
    logic rsv;
    logic ie;
  } twm_ctrl_t;

  // one bit per bus line
  typedef struct packed {
    logic scl;
    logic sda;
  } twm_pin_t;
endpackage : twm_pkg

// ==== rtl/twm_sync.sv ====
/*
  Two-stage synchroniser for the bus lines.
  Assumes inputs asynchronous to pclk; idle lines are high.
*/
module twm_sync #(
  parameter int W = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '1;
      q <= '1;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : twm_sync

// ==== rtl/twm_tick.sv ====
/*
  Quarter-bit tick generator with a 2-bit prescaler.
  Assumes pclk domain; period is BASE times 4 to the prescaler.
*/
`include "twm_cfg.svh"

module twm_tick #(
  parameter int unsigned BASE = `TWM_QTR_CYC,
  parameter int CW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic run,
  input wire logic [1:0] presc,
  output logic tick
);
  logic [CW-1:0] cnt;
  logic [CW-1:0] lim;

  // prescaler multiplies the quarter period by 1, 4, 16 or 64
  assign lim = CW'(BASE << (2 * presc)) - CW'(1);

  // counter restarts while disabled so phases align to the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      if (!run || cnt == lim) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + CW'(1);
      end
      tick <= run && cnt == lim;
    end
  end
endmodule : twm_tick

// ==== rtl/twm_top.sv ====
/*
  Two-wire bus master transmitter with an APB register port.
  Assumes open-drain bus lines outside (pin_oe high pulls low),
  a 100 MHz pclk, and software that follows the flag handshake.
*/
`include "twm_cfg.svh"

module twm_top #(
  parameter int unsigned QTR = `TWM_QTR_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire twm_pkg::twm_pin_t pin_in,
  output twm_pkg::twm_pin_t pin_out,
  output twm_pkg::twm_pin_t pin_oe,
  output logic irq
);
  twm_pkg::twm_state_t state;
  twm_pkg::twm_ctrl_t ctrl;
  twm_pkg::twm_ctrl_t wr_ctrl;
  twm_pkg::twm_pin_t pin_s;
  twm_pkg::twm_pin_t next_oe;
  logic [1:0] ph;
  logic [2:0] bitn;
  logic [7:0] shreg;
  logic [7:0] data;
  logic [7:0] code;
  logic [1:0] presc;
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;
  logic own;
  logic busy;
  logic sda_p;
  logic is_addr;
  logic rw;
  logic mode_rx;
  logic tick;
  logic stall;
  logic step;
  logic last;
  logic wr;
  logic rd;
  logic ctrl_wr;
  logic data_wr;
  logic cmd;
  logic mapped;
  logic ev_start;
  logic ev_ack;
  logic ev_lost;
  logic ev_stop;
  logic ev_wcol;
  logic [7:0] rd_mux;
  logic ack_bit;

  twm_sync #(
    .W(2)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d(pin_in),
    .q(pin_s)
  );

  twm_tick #(
    .BASE(QTR),
    .CW(16)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(ctrl.en),
    .presc(presc),
    .tick(tick)
  );

  // apb decode; every access completes in its first access cycle
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign ctrl_wr = wr && paddr == `TWM_A_CTRL;
  assign data_wr = wr && paddr == `TWM_A_DATA;
  assign mapped = paddr == `TWM_A_CTRL || paddr == `TWM_A_STAT ||
                  paddr == `TWM_A_DATA || paddr == `TWM_A_AUX ||
                  paddr == `TWM_A_ISTAT || paddr == `TWM_A_IMASK;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  // (R1) write with flag-clear and enable
  assign cmd = ctrl_wr && pwdata[`TWM_B_FLAG] && pwdata[`TWM_B_EN];
  // written byte seen through the control layout
  assign wr_ctrl = pwdata[7:0];

  // bit engine steps on quarter ticks; a slave may stretch scl
  assign stall = ph == 2'd1 && !pin_s.scl &&
                 (state == twm_pkg::S_BIT || state == twm_pkg::S_ACK ||
                  state == twm_pkg::S_START || state == twm_pkg::S_STOP);
  assign step = tick && !stall;
  assign last = step && ph == 2'd3;
  assign ev_start = state == twm_pkg::S_START && last;
  assign ev_ack = state == twm_pkg::S_ACK && last;
  assign ev_stop = state == twm_pkg::S_STOP && last;
  // (R13) released high bit read back low
  assign ev_lost = state == twm_pkg::S_BIT && step && ph == 2'd2 &&
                   shreg[7] && !pin_s.sda;
  assign ev_wcol = data_wr && !ctrl.flag;

  // transfer sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= twm_pkg::S_IDLE;
      ph <= 2'd0;
      bitn <= 3'd0;
      shreg <= 8'h00;
      own <= 1'b0;
      is_addr <= 1'b0;
    end else if (ce) begin
      // (R1) a start command that also enables is not lost
      if (!ctrl.en && !cmd) begin
        state <= twm_pkg::S_IDLE;
        ph <= 2'd0;
        own <= 1'b0;
      end else begin
        if (step) begin
          ph <= ph + 2'd1;
        end
        unique case (state)
          twm_pkg::S_IDLE: begin
            ph <= 2'd0;
            // (R1) wait for a free bus first
            if (cmd && pwdata[`TWM_B_STA]) begin
              state <= twm_pkg::S_WAIT;
            end
          end
          twm_pkg::S_WAIT: begin
            ph <= 2'd0;
            if (tick && !busy) begin
              state <= twm_pkg::S_START;
            end
          end
          twm_pkg::S_START: begin
            if (last) begin
              // (R10) ownership kept across repeated start
              own <= 1'b1;
              is_addr <= 1'b1;
              state <= twm_pkg::S_HOLD;
            end
          end
          twm_pkg::S_BIT: begin
            if (ev_lost) begin
              // (R13) drop the bus at once
              own <= 1'b0;
              ph <= 2'd0;
              state <= twm_pkg::S_HOLD;
            end else if (last) begin
              shreg <= {shreg[6:0], 1'b0};
              bitn <= bitn - 3'd1;
              if (bitn == 3'd0) begin
                state <= twm_pkg::S_ACK;
              end
            end
          end
          twm_pkg::S_ACK: begin
            if (last) begin
              is_addr <= 1'b0;
              state <= twm_pkg::S_HOLD;
            end
          end
          twm_pkg::S_HOLD: begin
            ph <= 2'd0;
            // (R6) nothing moves until software clears the flag
            if (cmd) begin
              if (!own) begin
                state <= pwdata[`TWM_B_STA] ? twm_pkg::S_WAIT
                                            : twm_pkg::S_IDLE;
              end else if (pwdata[`TWM_B_STO]) begin
                // (R9) stop requested
                state <= twm_pkg::S_STOP;
              end else if (pwdata[`TWM_B_STA]) begin
                // (R10) repeated start
                state <= twm_pkg::S_START;
              end else begin
                // (R11) eight bits, msb first
                shreg <= data;
                bitn <= `TWM_BITS;
                state <= twm_pkg::S_BIT;
              end
            end
          end
          twm_pkg::S_STOP: begin
            if (last) begin
              own <= 1'b0;
              // (R14) start follows stop once bus is free
              state <= ctrl.sta ? twm_pkg::S_WAIT : twm_pkg::S_IDLE;
            end
          end
          default: begin
            state <= twm_pkg::S_IDLE;
          end
        endcase
      end
    end
  end

  // line drive per state and quarter; high means pull low
  always_comb begin
    next_oe = '0;
    unique case (state)
      twm_pkg::S_START: begin
        next_oe.scl = (ph == 2'd0 && own) || ph == 2'd3;
        next_oe.sda = ph[1];
      end
      twm_pkg::S_BIT: begin
        next_oe.scl = ph == 2'd0 || ph == 2'd3;
        next_oe.sda = !shreg[7];
      end
      twm_pkg::S_ACK: begin
        next_oe.scl = ph == 2'd0 || ph == 2'd3;
      end
      twm_pkg::S_HOLD: begin
        // (R16) clock held low while owned
        next_oe.scl = own;
      end
      twm_pkg::S_STOP: begin
        next_oe.scl = ph == 2'd0;
        next_oe.sda = !ph[1];
      end
      default: begin
        next_oe = '0;
      end
    endcase
  end

  // registered pin enables keep the bus free of glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe <= '0;
    end else if (ce) begin
      pin_oe <= next_oe;
    end
  end
  assign pin_out = '0;

  // bus busy between a seen start and a seen stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_p <= 1'b1;
      busy <= 1'b0;
    end else if (ce) begin
      sda_p <= pin_s.sda;
      if (pin_s.scl && sda_p && !pin_s.sda) begin
        busy <= 1'b1;
      end else if (pin_s.scl && !sda_p && pin_s.sda) begin
        busy <= 1'b0;
      end
    end
  end

  // control register in one process: one driver for the whole struct
  // hardware flag set wins over software clear; rsv stays zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
    end else if (ce) begin
      // (R15) stop end is not a set source
      if (ev_start || ev_ack || ev_lost) begin
        ctrl.flag <= 1'b1;
      end else if (ctrl_wr && wr_ctrl.flag) begin
        ctrl.flag <= 1'b0;
      end
      if (ctrl_wr) begin
        ctrl.acken <= wr_ctrl.acken;
        ctrl.sta <= wr_ctrl.sta;
        ctrl.sto <= wr_ctrl.sto;
        ctrl.en <= wr_ctrl.en;
        ctrl.ie <= wr_ctrl.ie;
      end else if (ev_stop) begin
        // (R14) stop bit self-clears
        ctrl.sto <= 1'b0;
      end
      if (data_wr && ctrl.flag) begin
        ctrl.wc <= 1'b0;
      end else if (ev_wcol) begin
        // (R4) late write dropped
        ctrl.wc <= 1'b1;
      end
    end
  end

  // data register; a write with the flag low never lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data <= 8'h00;
      rw <= 1'b0;
    end else if (ce) begin
      if (data_wr && ctrl.flag) begin
        data <= pwdata[7:0];
      end
      if (state == twm_pkg::S_HOLD && cmd && is_addr) begin
        rw <= data[0];
      end
    end
  end

  // status code and prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code <= `TWM_C_IDLE;
      presc <= 2'd0;
      ack_bit <= 1'b1;
    end else if (ce) begin
      if (wr && paddr == `TWM_A_STAT) begin
        presc <= pwdata[1:0];
      end
      // (R11) ack taken while scl is high; slaves release after fall
      if (state == twm_pkg::S_ACK && step && ph == 2'd2) begin
        ack_bit <= pin_s.sda;
      end
      if (ev_start) begin
        // (R2) first start; (R10) repeated start
        code <= own ? `TWM_C_RSTART : `TWM_C_START;
      end else if (ev_lost) begin
        // (R13) arbitration lost
        code <= `TWM_C_LOST;
      end else if (ev_ack) begin
        // (R3) address answer; (R11) low is ack
        if (is_addr) begin
          code <= ack_bit ? `TWM_C_ANACK : `TWM_C_AACK;
        end else begin
          code <= ack_bit ? `TWM_C_DNACK : `TWM_C_DACK;
        end
      end else if (ev_stop) begin
        code <= `TWM_C_IDLE;
      end
    end
  end

  // (R8) direction bit of each address, after every start, picks the mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_rx <= 1'b0;
    end else if (ce) begin
      if (ev_ack && is_addr) begin
        mode_rx <= rw;
      end
    end
  end

  // sticky interrupt causes; a read clears, a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
    end else if (ce) begin
      if (wr && paddr == `TWM_A_IMASK) begin
        irq_mask <= pwdata[3:0];
      end
      irq_stat <= (rd && paddr == `TWM_A_ISTAT ? 4'h0 : irq_stat) |
                  {ev_stop, ev_wcol, ev_lost, ev_start | ev_ack | ev_lost};
    end
  end
  assign irq = |(irq_stat & irq_mask);

  // read data captured in the setup cycle
  always_comb begin
    unique case (paddr)
      `TWM_A_CTRL: rd_mux = ctrl;
      `TWM_A_STAT: rd_mux = {code[7:3], 1'b0, presc};
      `TWM_A_DATA: rd_mux = data;
      // (R12) only the master modes live here
      `TWM_A_AUX: rd_mux = {5'h00, busy, own, mode_rx};
      `TWM_A_ISTAT: rd_mux = {4'h0, irq_stat};
      `TWM_A_IMASK: rd_mux = {4'h0, irq_mask};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      if (psel && !penable && !pwrite) begin
        prdata <= {24'h00_0000, rd_mux};
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  sequence seq_start_req;
    state == twm_pkg::S_IDLE && cmd && pwdata[`TWM_B_STA];
  endsequence
  sequence seq_hold_cmd;
    state == twm_pkg::S_HOLD && ctrl.en && own && cmd;
  endsequence

  AST_START_REQ: assert property ( // (R1)
    seq_start_req |=> state == twm_pkg::S_WAIT
  ) else $error("start request not taken");
  AST_START_CODE: assert property ( // (R2)
    ev_start && !own |=> ctrl.flag && code == `TWM_C_START
  ) else $error("start code wrong");
  AST_ADDR_CODE: assert property ( // (R3)
    ev_ack && is_addr |=> ctrl.flag &&
      (code == `TWM_C_AACK || code == `TWM_C_ANACK)
  ) else $error("address code wrong");
  AST_WCOL: assert property ( // (R4)
    ev_wcol |=> ctrl.wc && data == $past(data)
  ) else $error("collision write not dropped");
  AST_SUSPEND: assert property ( // (R6)
    state == twm_pkg::S_HOLD && ctrl.en && !cmd
      |=> state == twm_pkg::S_HOLD
  ) else $error("transfer moved while suspended");
  AST_STOP_GO: assert property ( // (R9)
    seq_hold_cmd ##0 pwdata[`TWM_B_STO] |=> state == twm_pkg::S_STOP
  ) else $error("stop not started");
  AST_RSTART: assert property ( // (R10)
    ev_start && own |=> code == `TWM_C_RSTART && own && ctrl.flag
  ) else $error("repeated start code wrong");
  AST_LOST: assert property ( // (R13)
    ev_lost |=> code == `TWM_C_LOST && !own ##1 !pin_oe.scl && !pin_oe.sda
  ) else $error("bus not released after loss");
  AST_STOP_END: assert property ( // (R14)
    ev_stop && !ctrl_wr |=> !ctrl.sto
  ) else $error("stop bit not cleared");
  AST_NO_FLAG: assert property ( // (R15)
    ev_stop && !ctrl.flag |=> !ctrl.flag
  ) else $error("flag set after stop");
  AST_SCL_HELD: assert property ( // (R16)
    (state == twm_pkg::S_HOLD && own && ctrl.en)[*2] |-> pin_oe.scl
  ) else $error("clock not held low");
endmodule : twm_top

// ==== dv/twm_slave_model.sv ====
/*
  Behavioural two-wire slave receiver for the master transmitter bench.
  Assumes pull-ups on both lines and a pclk far faster than the bit rate.
*/
module twm_slave_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic nack,
  input wire logic slow,
  input wire logic contend,
  output logic scl_oe,
  output logic sda_oe,
  output logic rx_strobe,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_q, sda_q, active, ack_drv;
  logic [3:0] cnt;
  logic [7:0] shift;
  logic [5:0] hold;

  // frame tracking on line levels; the later assignment wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      active <= 1'b0;
      ack_drv <= 1'b0;
      cnt <= 4'h0;
      shift <= 8'h00;
      hold <= 6'h00;
      rx_strobe <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      rx_strobe <= 1'b0;
      if (hold != 6'h00) hold <= hold - 6'h01;
      if (scl && scl_q && sda_q && !sda) begin
        active <= 1'b1;
        cnt <= 4'h0;
        ack_drv <= 1'b0;
      end else if (scl && scl_q && !sda_q && sda) begin
        active <= 1'b0;
      end else if (active && scl && !scl_q && cnt < 4'h8) begin
        shift <= {shift[6:0], sda};
        cnt <= cnt + 4'h1;
      end else if (active && !scl && scl_q) begin
        if (slow) hold <= 6'h14;
        if (cnt == 4'h8 && !ack_drv) begin
          ack_drv <= 1'b1;
        end else if (ack_drv) begin
          ack_drv <= 1'b0;
          cnt <= 4'h0;
          rx_strobe <= 1'b1;
          rx_byte <= shift;
        end
      end
    end
  end

  // ack low, refusal leaves line high
  assign sda_oe = (ack_drv & ~nack) | (contend & active);
  // slow partner stretches every low phase
  assign scl_oe = (hold != 6'h00);
endmodule : twm_slave_model

// ==== dv/two_wire_master_transmitter_test.sv ====
/*
  Self-checking bench for the two-wire master transmitter.
  Assumes twm_top with a short quarter bit, pull-ups on both lines
  and the behavioural slave receiver on the far side.
*/
`include "twm_cfg.svh"

module two_wire_master_transmitter_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] v;
    logic [31:0] m;
    logic e;
  } twm_rd_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, s_scl_oe, s_sda_oe, rx_strobe;
  logic nack = 1'b0;
  logic slow = 1'b0;
  logic contend = 1'b0;
  logic [7:0] rx_byte;
  logic [6:0] addr;
  twm_pkg::twm_pin_t pin_oe;
  int fails = 0;
  int check_count = 0;
  twm_rd_t rd_q[$];
  twm_rd_t n;
  logic [7:0] exp_byte[$];
  // open-drain lines with pull-ups
  wire scl_w = ~(pin_oe.scl | s_scl_oe);
  wire sda_w = ~(pin_oe.sda | s_sda_oe);

  always #5 pclk = ~pclk;

  twm_top #(.QTR(4)) dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in({scl_w, sda_w}), .pin_out(), .pin_oe(pin_oe), .irq(irq));

  twm_slave_model partner (.pclk(pclk), .presetn(presetn), .scl(scl_w),
    .sda(sda_w), .nack(nack), .slow(slow), .contend(contend),
    .scl_oe(s_scl_oe), .sda_oe(s_sda_oe), .rx_strobe(rx_strobe),
    .rx_byte(rx_byte));

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    if (k == 100) begin
      fails++;
      stop_test();
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr

  // expectation noted; the monitor compares it
  task automatic rd(input logic [7:0] a, input logic [31:0] v,
                    input logic [31:0] m);
    logic [31:0] r;
    rd_q.push_back('{v: v, m: m, e: (a > 8'h14)});
    apb(1'b0, a, 32'h0, r);
  endtask : rd

  task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
    logic [31:0] r;
    int k;
    k = 0;
    do begin
      rd_q.push_back('{v: 32'h0, m: 32'h0, e: 1'b0});
      apb(1'b0, a, 32'h0, r);
      k++;
    end while (r[b] !== v && k < 2000);
    if (r[b] !== v) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, r[b], v);
      stop_test();
    end
  endtask : wait_bit

  task automatic go(input logic [7:0] c, input logic [7:0] code);
    wr(`TWM_A_CTRL, {24'h0, c});
    wait_bit(`TWM_A_CTRL, `TWM_B_FLAG, 1'b1);
    rd(`TWM_A_STAT, {24'h0, code}, 32'hF8);
  endtask : go

  task automatic send(input logic [7:0] b, input logic [7:0] code);
    wr(`TWM_A_DATA, {24'h0, b});
    exp_byte.push_back(b);
    go(8'h84, code);
  endtask : send

  // monitor: read data, error response and bytes seen by the partner
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      n = rd_q.pop_front();
      chk(prdata & n.m, n.v & n.m);
      chk({31'h0, pslverr}, {31'h0, n.e});
    end
    if (rx_strobe) chk({24'h0, rx_byte}, {24'h0, exp_byte.pop_front()});
  end

  initial begin
    void'($urandom(32'hFE8C));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped address
    rd(`TWM_A_CTRL, 32'h0, 32'hFF);
    rd(`TWM_A_STAT, 32'hF8, 32'hFF);
    rd(`TWM_A_ISTAT, 32'h0, 32'hFF);
    rd(8'h18, 32'h0, 32'hFFFFFFFF);
    $display("reset test done");
    // start request without flag clear must not start
    wr(`TWM_A_CTRL, 32'h24);
    repeat (100) @(posedge pclk);
    rd(`TWM_A_AUX, 32'h0, 32'h4);
    chk({30'h0, scl_w, sda_w}, 32'h3);
    // data write with flag low, interrupt masked then unmasked
    wr(`TWM_A_DATA, 32'h5A);
    rd(`TWM_A_CTRL, 32'h08, 32'h88);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(`TWM_A_IMASK, 32'h4);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    rd(`TWM_A_ISTAT, 32'h4, 32'h4);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(`TWM_A_IMASK, 32'h1);
    $display("collision test done");
    // write transfer with slow and refusing partner
    addr = 7'($urandom);
    // start straight from the disabled state
    wr(`TWM_A_CTRL, 32'h0);
    go(8'hA4, 8'h08);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, scl_w}, 32'h0);
    send({addr, 1'b0}, 8'h18);
    rd(`TWM_A_AUX, 32'h2, 32'h3);
    slow <= 1'b1;
    send(8'($urandom), 8'h28);
    slow <= 1'b0;
    nack <= 1'b1;
    send(8'($urandom), 8'h30);
    nack <= 1'b0;
    go(8'hA4, 8'h10);
    send({addr, 1'b1}, 8'h18);
    rd(`TWM_A_AUX, 32'h1, 32'h1);
    go(8'hB4, 8'h08);
    rd(`TWM_A_CTRL, 32'h0, 32'h10);
    nack <= 1'b1;
    send({addr, 1'b0}, 8'h20);
    nack <= 1'b0;
    wr(`TWM_A_CTRL, 32'h94);
    // ownership drops only once the stop has fully ended
    wait_bit(`TWM_A_AUX, 1, 1'b0);
    rd(`TWM_A_CTRL, 32'h0, 32'h90);
    rd(`TWM_A_STAT, 32'hF8, 32'hF8);
    rd(`TWM_A_ISTAT, 32'h8, 32'h8);
    chk({30'h0, scl_w, sda_w}, 32'h3);
    $display("transfer test done");
    // another master holds the data line low during the address
    go(8'hA4, 8'h08);
    contend <= 1'b1;
    wr(`TWM_A_DATA, 32'hFE);
    go(8'h84, 8'h38);
    rd(`TWM_A_AUX, 32'h0, 32'h2);
    contend <= 1'b0;
    wr(`TWM_A_CTRL, 32'h84);
    wait_bit(`TWM_A_AUX, 2, 1'b0);
    $display("arbitration test done");
    chk(32'(exp_byte.size()), 32'h0);
    stop_test();
  end
endmodule : two_wire_master_transmitter_test
